// [catb_pkg.sv]
package catb_pkg;
    localparam int unsigned CATB_ADDR_W = 12;
    localparam int unsigned CATB_DATA_W = 32;
    localparam int unsigned CATB_IDX_W  = 10;
    // Register indices; the byte address is four times the index
    localparam logic [9:0]  CATB_IDX_COEFF6  = 10'h064;
    localparam logic [9:0]  CATB_IDX_COEFF7  = 10'h065;
    localparam logic [9:0]  CATB_IDX_COEFF8  = 10'h066;
    localparam logic [9:0]  CATB_IDX_COEFF9  = 10'h067;
    localparam logic [9:0]  CATB_IDX_COEFF10 = 10'h068;
    localparam logic [9:0]  CATB_IDX_COEFF11 = 10'h069;
    localparam logic [9:0]  CATB_IDX_CTRL    = 10'h070;
    localparam logic [9:0]  CATB_IDX_STAT    = 10'h071;
    localparam logic [7:0]  CATB_COEFF_RESET = 8'h00;
    // Coefficient widths
    localparam int unsigned CATB_G2_W = 14;
    localparam int unsigned CATB_G3_W = 12;
    localparam int unsigned CATB_G4_W = 12;
    localparam int unsigned CATB_O0_W = 14;
    localparam int unsigned CATB_O1_W = 12;
    // Field positions of the split coefficients
    localparam int unsigned CATB_G2_HI_LSB = 11;
    localparam int unsigned CATB_G2_HI_W   = 3;
    localparam int unsigned CATB_G3_LO_W   = 5;
    localparam int unsigned CATB_G3_HI_W   = 7;
    localparam int unsigned CATB_G4_LO_W   = 8;
    localparam int unsigned CATB_G4_HI_W   = 4;
    localparam int unsigned CATB_O0_LO_W   = 4;
    localparam int unsigned CATB_O0_MID_W  = 8;
    localparam int unsigned CATB_O0_HI_LSB = 12;
    localparam int unsigned CATB_O0_HI_W   = 2;
    localparam int unsigned CATB_O1_LO_W   = 6;
    // Control and status bits
    localparam int unsigned CATB_CTRL_RELOAD = 0;
    localparam int unsigned CATB_STAT_LOADED = 0;
    localparam int unsigned CATB_STAT_BUSY   = 1;
    localparam int unsigned CATB_STAT_ERR    = 2;
    localparam int unsigned CATB_STAT_TMO    = 3;
    // AXI responses
    localparam logic [1:0]  CATB_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  CATB_RESP_DECERR = 2'h3;
    // Trim load timeout
    localparam int unsigned CATB_CLK_PERIOD_NS = 4;
    localparam int unsigned CATB_LOAD_TMO_NS   = 10000;
    localparam int unsigned CATB_LOAD_TMO_CYC  = CATB_LOAD_TMO_NS / CATB_CLK_PERIOD_NS;
    localparam int unsigned CATB_TMO_W         = 12;
    localparam logic [11:0] CATB_LOAD_TMO_LIM  = 12'(CATB_LOAD_TMO_CYC - 1);
    typedef enum logic {CATB_LOAD_IDLE, CATB_LOAD_WAIT} catb_load_state_t;
endpackage : catb_pkg

// [catb_axil_wr.sv]
`timescale 1ns/1ns
`default_nettype none
module catb_axil_wr (
    input  wire logic                             clock,
    input  wire logic                             rst_n,
    input  wire logic [catb_pkg::CATB_ADDR_W-1:0] awaddr,
    input  wire logic                             awvalid,
    output var  logic                             awready,
    input  wire logic [catb_pkg::CATB_DATA_W-1:0] wdata,
    input  wire logic [3:0]                       wstrb,
    input  wire logic                             wvalid,
    output var  logic                             wready,
    output var  logic [1:0]                       bresp,
    output var  logic                             bvalid,
    input  wire logic                             bready,
    output var  logic                             wr_en,
    output var  logic [catb_pkg::CATB_ADDR_W-1:0] wr_addr,
    output var  logic [catb_pkg::CATB_DATA_W-1:0] wr_data,
    output var  logic [3:0]                       wr_strb,
    input  wire logic [1:0]                       wr_resp
);
    import catb_pkg::*;
    logic aw_full_reg;
    logic w_full_reg;

    // Address and data are taken in either order; the write fires once both are held
    assign wr_en = aw_full_reg & w_full_reg & ~bvalid;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_reg <= 1'b0;
            awready     <= 1'b1;
            wr_addr     <= '0;
        end else if (awvalid && awready) begin
            aw_full_reg <= 1'b1;
            awready     <= 1'b0;
            wr_addr     <= awaddr;
        end else if (wr_en) begin
            aw_full_reg <= 1'b0;
        end else if (bvalid && bready) begin
            awready     <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w_full_reg <= 1'b0;
            wready     <= 1'b1;
            wr_data    <= '0;
            wr_strb    <= 4'h0;
        end else if (wvalid && wready) begin
            w_full_reg <= 1'b1;
            wready     <= 1'b0;
            wr_data    <= wdata;
            wr_strb    <= wstrb;
        end else if (wr_en) begin
            w_full_reg <= 1'b0;
        end else if (bvalid && bready) begin
            wready     <= 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bvalid <= 1'b0;
            bresp  <= CATB_RESP_OKAY;
        end else if (wr_en) begin
            bvalid <= 1'b1;
            bresp  <= wr_resp;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end
endmodule : catb_axil_wr
`default_nettype wire

// [catb_axil_rd.sv]
`timescale 1ns/1ns
`default_nettype none
module catb_axil_rd (
    input  wire logic                             clock,
    input  wire logic                             rst_n,
    input  wire logic [catb_pkg::CATB_ADDR_W-1:0] araddr,
    input  wire logic                             arvalid,
    output var  logic                             arready,
    output var  logic [catb_pkg::CATB_DATA_W-1:0] rdata,
    output var  logic [1:0]                       rresp,
    output var  logic                             rvalid,
    input  wire logic                             rready,
    output var  logic [catb_pkg::CATB_ADDR_W-1:0] rd_addr,
    input  wire logic [catb_pkg::CATB_DATA_W-1:0] rd_data,
    input  wire logic [1:0]                       rd_resp
);
    import catb_pkg::*;

    // The bank answers from the address as offered, so no address register is needed
    assign rd_addr = araddr;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= CATB_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= rd_data;
            rresp   <= rd_resp;
        end else if (rvalid && rready) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
        end
    end
endmodule : catb_axil_rd
`default_nettype wire

// [catb_trim_bank.sv]
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Index 0x64 bits 2..0 read gain term 2 bits 13..11, read-only, reset zero.
// - Gain term 2 bits 2..0 and 10..3 belong to indices 0x62 and 0x63 outside this bank.
// - Index 0x66 reads gain term 4 bits 7..0 over the whole byte, read-only, reset zero.
// - Index 0x67 bits 3..0 read gain term 4 bits 11..8, read-only, reset zero.
// - Index 0x67 bits 7..4 read offset term 0 bits 3..0, read-only, reset zero.
// - Index 0x68 reads offset term 0 bits 11..4 over the whole byte, read-only, reset zero.
// - Index 0x69 bits 1..0 read offset term 0 bits 13..12, read-only, reset zero.
// - Index 0x69 bits 7..2 read offset term 1 bits 5..0, read-only, reset zero.
module catb_trim_bank (
    input  wire logic                             clock,
    input  wire logic                             rst_n,
    input  wire logic [catb_pkg::CATB_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]                       s_axi_awprot,
    input  wire logic                             s_axi_awvalid,
    output var  logic                             s_axi_awready,
    input  wire logic [catb_pkg::CATB_DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                       s_axi_wstrb,
    input  wire logic                             s_axi_wvalid,
    output var  logic                             s_axi_wready,
    output var  logic [1:0]                       s_axi_bresp,
    output var  logic                             s_axi_bvalid,
    input  wire logic                             s_axi_bready,
    input  wire logic [catb_pkg::CATB_ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]                       s_axi_arprot,
    input  wire logic                             s_axi_arvalid,
    output var  logic                             s_axi_arready,
    output var  logic [catb_pkg::CATB_DATA_W-1:0] s_axi_rdata,
    output var  logic [1:0]                       s_axi_rresp,
    output var  logic                             s_axi_rvalid,
    input  wire logic                             s_axi_rready,
    output var  logic                             trim_req,
    input  wire logic                             trim_ack,
    input  wire logic                             trim_err,
    input  wire logic [catb_pkg::CATB_G2_W-1:0]   trim_gain2,
    input  wire logic [catb_pkg::CATB_G3_W-1:0]   trim_gain3,
    input  wire logic [catb_pkg::CATB_G4_W-1:0]   trim_gain4,
    input  wire logic [catb_pkg::CATB_O0_W-1:0]   trim_offset0,
    input  wire logic [catb_pkg::CATB_O1_W-1:0]   trim_offset1,
    output var  logic [catb_pkg::CATB_G2_W-1:0]   gain_tempco_term2,
    output var  logic [catb_pkg::CATB_G3_W-1:0]   gain_tempco_term3,
    output var  logic [catb_pkg::CATB_G4_W-1:0]   gain_tempco_term4,
    output var  logic [catb_pkg::CATB_O0_W-1:0]   offset_tempco_term0,
    output var  logic [catb_pkg::CATB_O1_W-1:0]   offset_tempco_term1,
    output var  logic                             coeff_valid
);
    import catb_pkg::*;

    // Word index from a byte address; byte lanes inside a word are not decoded
    function automatic logic [CATB_IDX_W-1:0] catb_idx(
        input logic [CATB_ADDR_W-1:0] addr
    );
        catb_idx = addr[CATB_ADDR_W-1:2];
    endfunction : catb_idx

    function automatic logic catb_mapped(
        input logic [CATB_IDX_W-1:0] idx
    );
        catb_mapped = (idx >= CATB_IDX_COEFF6 && idx <= CATB_IDX_COEFF11)
                    || idx == CATB_IDX_CTRL
                    || idx == CATB_IDX_STAT;
    endfunction : catb_mapped

    logic                   wr_en;
    logic [CATB_ADDR_W-1:0] wr_addr;
    logic [CATB_DATA_W-1:0] wr_data;
    logic [3:0]             wr_strb;
    logic [1:0]             wr_resp;
    logic [CATB_ADDR_W-1:0] rd_addr;
    logic [CATB_DATA_W-1:0] rd_data;
    logic [1:0]             rd_resp;
    logic [CATB_IDX_W-1:0]  wr_idx;
    logic [CATB_IDX_W-1:0]  rd_idx;
    logic                   reload_wr;
    logic                   stat_wr;

    catb_axil_wr u_wr (
        .clock   (clock),
        .rst_n   (rst_n),
        .awaddr  (s_axi_awaddr),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .bresp   (s_axi_bresp),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .wr_en   (wr_en),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_resp (wr_resp)
    );

    catb_axil_rd u_rd (
        .clock   (clock),
        .rst_n   (rst_n),
        .araddr  (s_axi_araddr),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_resp (rd_resp)
    );

    // Protection bits carry no meaning for a trim bank
    logic unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

    assign wr_idx  = catb_idx(wr_addr);
    assign rd_idx  = catb_idx(rd_addr);
    assign wr_resp = catb_mapped(wr_idx) ? CATB_RESP_OKAY : CATB_RESP_DECERR;
    assign rd_resp = catb_mapped(rd_idx) ? CATB_RESP_OKAY : CATB_RESP_DECERR;

    // Only the low byte lane holds control and status bits
    assign reload_wr = wr_en && wr_idx == CATB_IDX_CTRL && wr_strb[0]
                    && wr_data[CATB_CTRL_RELOAD];
    assign stat_wr   = wr_en && wr_idx == CATB_IDX_STAT && wr_strb[0];

    // Trim load sequencer
    catb_load_state_t load_state_reg;
    logic [CATB_TMO_W-1:0] tmo_cnt_reg;
    logic                  loaded_reg;
    logic                  err_reg;
    logic                  tmo_reg;
    logic                  load_ok;
    logic                  load_bad;
    logic                  load_tmo;

    assign load_ok  = load_state_reg == CATB_LOAD_WAIT && trim_ack && !trim_err;
    assign load_bad = load_state_reg == CATB_LOAD_WAIT && trim_ack && trim_err;
    assign load_tmo = load_state_reg == CATB_LOAD_WAIT && !trim_ack
                    && tmo_cnt_reg == CATB_LOAD_TMO_LIM;

    // A load is requested straight out of reset, so the bank fills without software
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            load_state_reg <= CATB_LOAD_WAIT;
        end else begin
            unique case (load_state_reg)
                CATB_LOAD_IDLE: begin
                    if (reload_wr) begin
                        load_state_reg <= CATB_LOAD_WAIT;
                    end
                end
                CATB_LOAD_WAIT: begin
                    if (trim_ack || load_tmo) begin
                        load_state_reg <= CATB_LOAD_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            trim_req <= 1'b1;
        end else if (load_state_reg == CATB_LOAD_IDLE) begin
            trim_req <= reload_wr;
        end else if (trim_ack || load_tmo) begin
            trim_req <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tmo_cnt_reg <= '0;
        end else if (load_state_reg == CATB_LOAD_WAIT) begin
            tmo_cnt_reg <= tmo_cnt_reg + 1'b1;
        end else begin
            tmo_cnt_reg <= '0;
        end
    end

    // Error flags: the hardware set wins over a software write-one clear
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= 1'b0;
        end else if (load_bad) begin
            err_reg <= 1'b1;
        end else if (stat_wr && wr_data[CATB_STAT_ERR]) begin
            err_reg <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tmo_reg <= 1'b0;
        end else if (load_tmo) begin
            tmo_reg <= 1'b1;
        end else if (stat_wr && wr_data[CATB_STAT_TMO]) begin
            tmo_reg <= 1'b0;
        end
    end

    // A failed reload keeps the last good coefficients in use
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            loaded_reg  <= 1'b0;
            coeff_valid <= 1'b0;
        end else begin
            if (load_ok) begin
                loaded_reg <= 1'b1;
            end
            coeff_valid <= loaded_reg || load_ok;
        end
    end

    // Coefficient storage; only the trim load path can change it
    // Bus writes ignored
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            gain_tempco_term2   <= '0;
            gain_tempco_term3   <= '0;
            gain_tempco_term4   <= '0;
            offset_tempco_term0 <= '0;
            offset_tempco_term1 <= '0;
        end else if (load_ok) begin
            gain_tempco_term2   <= trim_gain2;
            gain_tempco_term3   <= trim_gain3;
            gain_tempco_term4   <= trim_gain4;
            offset_tempco_term0 <= trim_offset0;
            offset_tempco_term1 <= trim_offset1;
        end
    end

    // Read data assembly; bytes sit in the low lane and upper lanes read zero
    logic [7:0] rd_byte;

    always_comb begin
        rd_byte = CATB_COEFF_RESET;
        unique case (rd_idx)
            CATB_IDX_COEFF6: begin
                rd_byte = {gain_tempco_term3[0 +: CATB_G3_LO_W],
                           gain_tempco_term2[CATB_G2_HI_LSB +: CATB_G2_HI_W]};
            end
            CATB_IDX_COEFF7: begin
                rd_byte = {1'b0,
                           gain_tempco_term3[CATB_G3_LO_W +: CATB_G3_HI_W]};
            end
            CATB_IDX_COEFF8: begin
                rd_byte = gain_tempco_term4[0 +: CATB_G4_LO_W];
            end
            CATB_IDX_COEFF9: begin
                rd_byte = {offset_tempco_term0[0 +: CATB_O0_LO_W],
                           gain_tempco_term4[CATB_G4_LO_W +: CATB_G4_HI_W]};
            end
            CATB_IDX_COEFF10: begin
                rd_byte = offset_tempco_term0[CATB_O0_LO_W +: CATB_O0_MID_W];
            end
            CATB_IDX_COEFF11: begin
                rd_byte = {offset_tempco_term1[0 +: CATB_O1_LO_W],
                           offset_tempco_term0[CATB_O0_HI_LSB +: CATB_O0_HI_W]};
            end
            CATB_IDX_STAT: begin
                rd_byte[CATB_STAT_LOADED] = loaded_reg;
                rd_byte[CATB_STAT_BUSY]   = load_state_reg == CATB_LOAD_WAIT;
                rd_byte[CATB_STAT_ERR]    = err_reg;
                rd_byte[CATB_STAT_TMO]    = tmo_reg;
            end
            default: begin
                rd_byte = CATB_COEFF_RESET;
            end
        endcase
    end

    // Lower gain term 2 bits
    // Those bits are served by the neighbouring bank; here the full term is only driven out
    assign rd_data = {{(CATB_DATA_W - 8){1'b0}}, rd_byte};

endmodule : catb_trim_bank
`default_nettype wire

// [catb_trim_bank_sva.sv]
`timescale 1ns/1ns
`default_nettype none
module catb_trim_bank_sva
    import catb_pkg::*;
(
    input wire logic                                clock,
    input wire logic                                rst_n,
    input wire logic [catb_pkg::CATB_ADDR_W-1:0]    s_axi_araddr,
    input wire logic                                s_axi_arvalid,
    input wire logic                                s_axi_arready,
    input wire logic                                s_axi_rvalid,
    input wire logic [catb_pkg::CATB_DATA_W-1:0]    s_axi_rdata,
    input wire logic                                trim_req,
    input wire logic                                trim_ack,
    input wire logic                                trim_err,
    input wire logic [catb_pkg::CATB_G2_W-1:0]      trim_gain2,
    input wire logic [catb_pkg::CATB_G3_W-1:0]      trim_gain3,
    input wire logic [catb_pkg::CATB_G4_W-1:0]      trim_gain4,
    input wire logic [catb_pkg::CATB_O0_W-1:0]      trim_offset0,
    input wire logic [catb_pkg::CATB_O1_W-1:0]      trim_offset1,
    input wire logic [catb_pkg::CATB_G2_W-1:0]      gain_tempco_term2,
    input wire logic [catb_pkg::CATB_G3_W-1:0]      gain_tempco_term3,
    input wire logic [catb_pkg::CATB_G4_W-1:0]      gain_tempco_term4,
    input wire logic [catb_pkg::CATB_O0_W-1:0]      offset_tempco_term0,
    input wire logic [catb_pkg::CATB_O1_W-1:0]      offset_tempco_term1,
    input wire logic                                coeff_valid
);
    logic        good_load;
    logic [63:0] coeff_all;
    logic [7:0]  byte_6, byte_7, byte_8, byte_9, byte_10, byte_11;
    assign good_load = trim_req && trim_ack && !trim_err;
    assign coeff_all = {gain_tempco_term2, gain_tempco_term3, gain_tempco_term4,
                        offset_tempco_term0, offset_tempco_term1};
    assign byte_6  = {gain_tempco_term3[4:0], gain_tempco_term2[13:11]};
    assign byte_7  = {1'b0, gain_tempco_term3[11:5]};
    assign byte_8  = gain_tempco_term4[7:0];
    assign byte_9  = {offset_tempco_term0[3:0], gain_tempco_term4[11:8]};
    assign byte_10 = offset_tempco_term0[11:4];
    assign byte_11 = {offset_tempco_term1[5:0], offset_tempco_term0[13:12]};
    default clocking dflt_cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence rd_taken(logic [9:0] idx);
        s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == idx;
    endsequence
    // Data is the register content from before the taking edge
    property rd_byte(logic [9:0] idx, logic [7:0] b);
        rd_taken(idx) |=> s_axi_rvalid && s_axi_rdata == {24'h0, $past(b)};
    endproperty
    byte64_a: assert property (rd_byte(CATB_IDX_COEFF6, byte_6))
        else $error("byte at index 0x64 wrong");
    byte65_a: assert property (rd_byte(CATB_IDX_COEFF7, byte_7))
        else $error("byte at index 0x65 wrong");
    byte66_a: assert property (rd_byte(CATB_IDX_COEFF8, byte_8))
        else $error("byte at index 0x66 wrong");
    byte67_a: assert property (rd_byte(CATB_IDX_COEFF9, byte_9))
        else $error("byte at index 0x67 wrong");
    byte68_a: assert property (rd_byte(CATB_IDX_COEFF10, byte_10))
        else $error("byte at index 0x68 wrong");
    byte69_a: assert property (rd_byte(CATB_IDX_COEFF11, byte_11))
        else $error("byte at index 0x69 wrong");
    coeff_stable_a: assert property (!good_load |=> $stable(coeff_all))
        else $error("coefficients changed without a good load");
    load_gain_a: assert property (good_load |=> coeff_valid && !trim_req
        && gain_tempco_term2 == $past(trim_gain2) && gain_tempco_term3 == $past(trim_gain3)
        && gain_tempco_term4 == $past(trim_gain4)) else $error("gain load wrong");
    load_offset_a: assert property (good_load |=>
        offset_tempco_term0 == $past(trim_offset0) && offset_tempco_term1 == $past(trim_offset1))
        else $error("offset load wrong");
endmodule : catb_trim_bank_sva
bind catb_trim_bank catb_trim_bank_sva chk_u (
    .clock, .rst_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rdata,
    .trim_req, .trim_ack, .trim_err, .trim_gain2, .trim_gain3, .trim_gain4, .trim_offset0,
    .trim_offset1, .gain_tempco_term2, .gain_tempco_term3, .gain_tempco_term4,
    .offset_tempco_term0, .offset_tempco_term1, .coeff_valid
);
`default_nettype wire

// [catb_trim_bank_test.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin fail_count++; \
    $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module catb_trim_bank_test;
    import catb_pkg::*;
    typedef struct packed {logic [9:0] idx; logic [7:0] exp_a, exp_b; logic [1:0] resp;} catb_row_t;
    localparam catb_row_t ROWS [7] = '{'{CATB_IDX_COEFF6, 8'hD5, 8'h2A, CATB_RESP_OKAY},
        '{CATB_IDX_COEFF7, 8'h5A, 8'h25, CATB_RESP_OKAY}, '{CATB_IDX_COEFF8, 8'hC9, 8'h36, 2'h0},
        '{CATB_IDX_COEFF9, 8'hB3, 8'h4C, 2'h0}, '{CATB_IDX_COEFF10, 8'hE7, 8'h18, 2'h0},
        '{CATB_IDX_COEFF11, 8'hB5, 8'h4A, 2'h0}, '{10'h3FF, 8'h00, 8'h00, CATB_RESP_DECERR}};
    localparam logic [63:0] SET_A = {14'h2AC5, 12'hB5A, 12'h3C9, 14'h1E7B, 12'h96D};
    localparam int CYCLE_LIMIT = 5000;
    logic                   clock, rst_n;
    logic [CATB_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [CATB_DATA_W-1:0] s_axi_wdata, s_axi_rdata, rd_word;
    logic [3:0]             s_axi_wstrb;
    logic [1:0]             s_axi_bresp, s_axi_rresp, resp;
    logic                   s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic                   s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic                   s_axi_rvalid, s_axi_rready, trim_req, trim_ack, trim_err, coeff_valid;
    logic [CATB_G2_W-1:0]   trim_gain2, gain_tempco_term2;
    logic [CATB_G3_W-1:0]   trim_gain3, gain_tempco_term3;
    logic [CATB_G4_W-1:0]   trim_gain4, gain_tempco_term4;
    logic [CATB_O0_W-1:0]   trim_offset0, offset_tempco_term0;
    logic [CATB_O1_W-1:0]   trim_offset1, offset_tempco_term1;
    int                     fail_count = 0, total_checks = 0, cycle_count = 0;
    catb_trim_bank dut_u (.clock, .rst_n, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .trim_req,
        .trim_ack, .trim_err, .trim_gain2, .trim_gain3, .trim_gain4, .trim_offset0, .trim_offset1,
        .gain_tempco_term2, .gain_tempco_term3, .gain_tempco_term4, .offset_tempco_term0,
        .offset_tempco_term1, .coeff_valid);
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    always @(posedge clock) begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == CYCLE_LIMIT) begin
            fail_count++;
            $display("ERROR cycle_limit expected %0d seen %0d", CYCLE_LIMIT - 1, cycle_count);
            tally_and_finish();
        end
    end
    task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd
    task automatic wr(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] r);
        @(posedge clock);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clock);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr
    // Mode 0 expects reset zeros, 1 the first set, 2 the second set
    task automatic run_rows(input int mode);
        logic [31:0] d;
        logic [7:0]  e;
        foreach (ROWS[k]) begin
            rd(ROWS[k].idx, d, resp);
            e = (mode == 0) ? 8'h00 : (mode == 1) ? ROWS[k].exp_a : ROWS[k].exp_b;
            `CHK("rdata", {24'h0, e}, d)
            `CHK("rresp", ROWS[k].resp, resp)
        end
    endtask : run_rows
    // A load is offered once the block asks for one, or after nine clock edges without a request
    task automatic load(input logic err, input logic [63:0] v);
        int i;
        i = 0;
        do @(posedge clock); while (!trim_req && i++ < 8);
        `CHK("trim_req", 1'b1, trim_req)
        {trim_gain2, trim_gain3, trim_gain4, trim_offset0, trim_offset1} <= v;
        trim_err <= err;
        trim_ack <= 1'b1;
        @(posedge clock);
        trim_ack <= 1'b0;
        @(posedge clock);
        `CHK("trim_req", 1'b0, trim_req)
        `CHK("coeff_valid", 1'b1, coeff_valid)
    endtask : load
    initial begin
        rst_n = 1'b0;
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_araddr, s_axi_arvalid, s_axi_rready, trim_ack, trim_err} = '0;
        {trim_gain2, trim_gain3, trim_gain4, trim_offset0, trim_offset1} = '0;
        repeat (8) @(posedge clock);
        `CHK("coeff_valid", 1'b0, coeff_valid)
        rst_n <= 1'b1;
        run_rows(0);
        $display("test reset values done");
        load(1'b0, SET_A);
        run_rows(1);
        $display("test first load done");
        foreach (ROWS[k]) begin
            wr(ROWS[k].idx, 32'hFFFF_FFFF, resp);
            `CHK("bresp", ROWS[k].resp, resp)
        end
        run_rows(1);
        $display("test write ignore done");
        wr(CATB_IDX_CTRL, 32'h0000_0001, resp);
        load(1'b1, ~SET_A);
        run_rows(1);
        rd(CATB_IDX_STAT, rd_word, resp);
        `CHK("status", 32'h5, rd_word)
        $display("test failed load done");
        wr(CATB_IDX_CTRL, 32'h0000_0001, resp);
        load(1'b0, ~SET_A);
        run_rows(2);
        $display("test reload done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        `CHK("coeff_valid", 1'b0, coeff_valid)
        rst_n <= 1'b1;
        run_rows(0);
        repeat (CATB_LOAD_TMO_CYC) @(posedge clock);
        rd(CATB_IDX_STAT, rd_word, resp);
        `CHK("status", 32'h8, rd_word)
        $display("test second reset done");
        tally_and_finish();
    end
endmodule : catb_trim_bank_test
`default_nettype wire
